// >>> hdl/nbv_channel.sv
`timescale 1ns/1ps
// One flash channel: eight banks, two bus lanes, paired ready/busy
module nbv_channel
   import nbv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire logic [NBV_BANK_W-1:0] cmd_bank,
   input wire logic [1:0] cmd_op,
   input wire logic cmd_low_dis,
   input wire logic cmd_high_dis,
   input wire logic [NBV_RB_PER_CH-1:0] rb_n,
   input wire logic ecc_fix,
   output logic cmd_ready,
   output logic [NBV_BANKS-1:0] ce_low_n,
   output logic [NBV_BANKS-1:0] ce_high_n,
   output logic [NBV_BANKS-1:0] bank_busy,
   output logic [1:0] lane_busy,
   output logic copy_fixed
);
   logic [NBV_RB_PER_CH-1:0] pair_busy;
   logic [NBV_BANKS-1:0] xfer_on;
   logic [NBV_BANKS-1:0] start_cell;
   logic [1:0] lanes_nxt;
   logic lane_free;
   logic pair_free;
   nbv_bstate_t st_r [NBV_BANKS];
   logic [3:0] cnt_r [NBV_BANKS];
   logic [1:0] op_r [NBV_BANKS];
   logic [NBV_BANKS-1:0] lo_dis_r;
   logic [NBV_BANKS-1:0] hi_dis_r;

   // One ready/busy guard per pair k / k+4
   genvar g;
   generate
      for (g = 0; g < NBV_RB_PER_CH; g++) begin : g_pair
         nbv_rb_pair u_pair (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .start_lo(start_cell[g]),
            .start_hi(start_cell[g+NBV_RB_PER_CH]),
            .rb_n(rb_n[g]),
            .busy(pair_busy[g])
         );
      end
   endgenerate

   // Count banks currently on the shared bus; two may transfer at once
   always_comb begin
      lanes_nxt = 2'h0;
      for (int i = 0; i < NBV_BANKS; i++) begin
         xfer_on[i] = (st_r[i] == NBV_XFER);
         start_cell[i] = (st_r[i] == NBV_XFER) && (cnt_r[i] == 4'h1);
         // A copy-back rewrite drives the bus too, so it holds a lane
         if ((xfer_on[i] || st_r[i] == NBV_FIX) && lanes_nxt != 2'h2)
            lanes_nxt = lanes_nxt + 2'h1;
      end
   end
   assign lane_free = (lanes_nxt < 2'(NBV_MAX_XFER));
   assign pair_free = !pair_busy[cmd_bank[1:0]] &&
                      (st_r[cmd_bank] == NBV_IDLE) &&
                      (st_r[cmd_bank ^ 3'h4] == NBV_IDLE);
   assign cmd_ready = lane_free && pair_free;

   // Per-bank sequencer: bus transfer, then cell operation
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < NBV_BANKS; i++) begin
            st_r[i] <= NBV_IDLE;
            cnt_r[i] <= 4'h0;
            op_r[i] <= 2'h0;
         end
         lo_dis_r <= '0;
         hi_dis_r <= '0;
      end else begin
         for (int i = 0; i < NBV_BANKS; i++) begin
            case (st_r[i])
               NBV_IDLE: begin
                  if (cmd_valid && cmd_ready && cmd_bank == 3'(i)) begin
                     st_r[i] <= NBV_XFER;
                     cnt_r[i] <= NBV_XFER_CNT;
                     op_r[i] <= cmd_op;
                     lo_dis_r[i] <= cmd_low_dis;
                     hi_dis_r[i] <= cmd_high_dis;
                  end
               end
               NBV_XFER: begin
                  cnt_r[i] <= cnt_r[i] - 4'h1;
                  if (cnt_r[i] == 4'h1) st_r[i] <= NBV_CELL;
               end
               NBV_CELL: begin
                  // Copy-back with a correction rewrites from the copy buffer
                  if (!pair_busy[i % NBV_RB_PER_CH]) begin
                     if (op_r[i] == NBV_OP_COPY && ecc_fix) begin
                        st_r[i] <= NBV_FIX;
                        cnt_r[i] <= NBV_XFER_CNT;
                     end else begin
                        st_r[i] <= NBV_IDLE;
                     end
                  end
               end
               NBV_FIX: begin
                  cnt_r[i] <= cnt_r[i] - 4'h1;
                  if (cnt_r[i] == 4'h1) st_r[i] <= NBV_IDLE;
               end
               default: st_r[i] <= NBV_IDLE;
            endcase
         end
      end
   end

   // Both enables move together unless a chip is disabled
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ce_low_n <= '1;
         ce_high_n <= '1;
         bank_busy <= '0;
         lane_busy <= 2'h0;
         copy_fixed <= 1'b0;
      end else begin
         for (int i = 0; i < NBV_BANKS; i++) begin
            ce_low_n[i] <= !(xfer_on[i] || st_r[i] == NBV_FIX) || lo_dis_r[i];
            ce_high_n[i] <= !(xfer_on[i] || st_r[i] == NBV_FIX) || hi_dis_r[i];
            bank_busy[i] <= (st_r[i] != NBV_IDLE);
         end
         lane_busy <= lanes_nxt;
         copy_fixed <= 1'b0;
         for (int i = 0; i < NBV_BANKS; i++)
            if (st_r[i] == NBV_FIX && cnt_r[i] == 4'h1) copy_fixed <= 1'b1;
      end
   end
endmodule : nbv_channel

// >>> hdl/nbv_pkg.sv
// Package: constants and types for the NAND bank virtualizer
package nbv_pkg;
   localparam int NBV_CHANNELS = 4;
   localparam int NBV_BANKS = 8;
   localparam int NBV_BANK_W = 3;
   localparam int NBV_RB_PER_CH = 4;
   localparam int NBV_BUS_W = 16;
   localparam int NBV_BYTE_W = 8;
   localparam int NBV_MAX_XFER = 2;
   localparam int NBV_PAGE_W = 16;
   localparam int NBV_BLOCK_W = 16;
   localparam int NBV_ROW_W = 24;
   localparam logic [31:0] NBV_REG_BASE = 32'h6000_0000;
   localparam int NBV_REG_BANKS = 32;
   localparam logic [1:0] NBV_SP_PAGE_MULT = 2'h2;
   localparam logic [2:0] NBV_TP_PAGE_MULT = 3'h4;
   // Operation codes on the command port
   localparam logic [1:0] NBV_OP_READ = 2'h0;
   localparam logic [1:0] NBV_OP_PROG = 2'h1;
   localparam logic [1:0] NBV_OP_ERASE = 2'h2;
   localparam logic [1:0] NBV_OP_COPY = 2'h3;
   // Cycles a transfer owns one of the bus lanes
   localparam int NBV_XFER_CYC = 4;
   localparam logic [3:0] NBV_XFER_CNT = 4'h4;
   typedef enum logic [1:0] {NBV_IDLE, NBV_XFER, NBV_CELL, NBV_FIX} nbv_bstate_t;
endpackage : nbv_pkg

// >>> hdl/nbv_rb_pair.sv
`timescale 1ns/1ps
// Shared ready/busy guard for one pair of banks
module nbv_rb_pair
   import nbv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic start_lo,
   input wire logic start_hi,
   input wire logic rb_n,
   output logic busy
);
   logic busy_r;
   logic seen_r;
   // Busy holds from start until the line has dropped and returned ready
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_r <= 1'b0;
         seen_r <= 1'b0;
      end else if (start_lo || start_hi) begin
         busy_r <= 1'b1;
         seen_r <= 1'b0;
      end else if (busy_r && !rb_n) begin
         seen_r <= 1'b1;
      end else if (busy_r && seen_r && rb_n) begin
         busy_r <= 1'b0;
      end
   end
   assign busy = busy_r || !rb_n;
endmodule : nbv_rb_pair

// >>> hdl/nbv_top.sv
`timescale 1ns/1ps
// Top of the NAND bank virtualizer: channels, virtual mapping, data lanes
// Notes on behaviour
// - Four channels run independently in parallel
// - Eight two-chip banks per channel, 16-bit bus
// - High chip upper byte, low chip lower
// - Both chip enables together unless disabled
// - Two banks per channel may transfer together
// - One ready/busy line per bank pair
// - Never cell operations on paired banks together
// - Page spans both chips; twice physical size
// - Two-plane joins two blocks; four times size
// - Two-plane keeps pages, halves block count
// - Erase virtualised like reads and writes
// - Disabled chip ignores commands and data
// - Chip disable with ECC raises corruption event
// - Copy-back stays within one chip plane
// - Copy-back rewrites corrected data, else direct
// - Buffers move to and from flash by DMA
// - Register region base, space for 32 banks
module nbv_top
   import nbv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic two_plane_mode,
   input wire logic cmd_valid,
   input wire logic [1:0] cmd_channel,
   input wire logic [NBV_BANK_W-1:0] cmd_bank,
   input wire logic [1:0] cmd_op,
   input wire logic [NBV_BLOCK_W-1:0] virtual_block,
   input wire logic [NBV_PAGE_W-1:0] virtual_page,
   input wire logic low_chip_disable,
   input wire logic high_chip_disable,
   input wire logic ecc_enable_option,
   input wire logic [NBV_CHANNELS*NBV_RB_PER_CH-1:0] rb_n,
   input wire logic ecc_fix,
   input wire logic dma_valid,
   input wire logic [NBV_BUS_W-1:0] dma_wdata,
   input wire logic [NBV_BUS_W-1:0] flash_rdata,
   output logic cmd_ready,
   output logic [NBV_ROW_W-1:0] phys_row0,
   output logic [NBV_ROW_W-1:0] phys_row1,
   output logic phys_two_plane,
   output logic [NBV_BLOCK_W-1:0] virt_block_count,
   output logic [3:0] page_mult,
   output logic ecc_corrupt_irq,
   output logic copy_fixed,
   output logic [NBV_CHANNELS*NBV_BANKS-1:0] ce_low_n,
   output logic [NBV_CHANNELS*NBV_BANKS-1:0] ce_high_n,
   output logic [NBV_CHANNELS*NBV_BANKS-1:0] bank_busy,
   output logic [NBV_BYTE_W-1:0] flash_low_out,
   output logic [NBV_BYTE_W-1:0] flash_high_out,
   output logic [NBV_BUS_W-1:0] dma_rdata,
   output logic [31:0] bank_reg_addr
);
   // Physical blocks per chip, fixed for this array size
   localparam logic [NBV_BLOCK_W-1:0] PHYS_BLOCKS = 16'h1000;

   logic [NBV_CHANNELS-1:0] ch_ready;
   logic [NBV_CHANNELS-1:0] ch_valid;
   logic [NBV_CHANNELS-1:0] ch_fixed;
   logic [NBV_CHANNELS*NBV_BANKS-1:0] ce_lo_w;
   logic [NBV_CHANNELS*NBV_BANKS-1:0] ce_hi_w;
   logic [NBV_CHANNELS*NBV_BANKS-1:0] busy_w;
   logic sel_ready;
   logic take;
   logic [NBV_BLOCK_W-1:0] blk_a;
   logic [NBV_BLOCK_W-1:0] blk_b;
   logic [NBV_ROW_W-1:0] row_a;
   logic [NBV_ROW_W-1:0] row_b;
   logic [4:0] bank_index;
   logic cmd_has_dis;
   logic cmd_is_copy;

   // Four independent channels, each steered by the channel field
   genvar c;
   generate
      for (c = 0; c < NBV_CHANNELS; c++) begin : g_ch
         assign ch_valid[c] = cmd_valid && (cmd_channel == 2'(c));
         nbv_channel u_ch (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .cmd_valid(ch_valid[c]),
            .cmd_bank(cmd_bank),
            .cmd_op(cmd_op),
            .cmd_low_dis(low_chip_disable),
            .cmd_high_dis(high_chip_disable),
            .rb_n(rb_n[c*NBV_RB_PER_CH +: NBV_RB_PER_CH]),
            .ecc_fix(ecc_fix),
            .cmd_ready(ch_ready[c]),
            .ce_low_n(ce_lo_w[c*NBV_BANKS +: NBV_BANKS]),
            .ce_high_n(ce_hi_w[c*NBV_BANKS +: NBV_BANKS]),
            .bank_busy(busy_w[c*NBV_BANKS +: NBV_BANKS]),
            .lane_busy(),
            .copy_fixed(ch_fixed[c])
         );
      end
   endgenerate

   // Command acceptance and address virtualisation
   assign sel_ready = ch_ready[cmd_channel];
   assign take = cmd_valid && sel_ready;
   assign blk_a = two_plane_mode ? {virtual_block[NBV_BLOCK_W-2:0], 1'b0}
                                 : virtual_block;
   assign blk_b = {virtual_block[NBV_BLOCK_W-2:0], 1'b1};
   // Pages per block unchanged in two-plane mode
   assign row_a = {blk_a[15:0], virtual_page[7:0]};
   assign row_b = {blk_b[15:0], virtual_page[7:0]};
   assign cmd_has_dis = low_chip_disable || high_chip_disable;
   assign cmd_is_copy = (cmd_op == NBV_OP_COPY);
   // Per-bank register slot in the 32-bank region
   assign bank_index = {cmd_channel, cmd_bank};

   // Registered mapping results
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phys_row0 <= '0;
         phys_row1 <= '0;
         phys_two_plane <= 1'b0;
         bank_reg_addr <= NBV_REG_BASE;
      end else if (take) begin
         phys_row0 <= row_a;
         // Copy-back source and target share one plane of one chip
         phys_row1 <= (two_plane_mode && !cmd_is_copy) ? row_b : row_a;
         phys_two_plane <= two_plane_mode && !cmd_is_copy;
         bank_reg_addr <= NBV_REG_BASE + {25'h0, bank_index, 2'h0};
      end
   end

   // Sizes seen by firmware, halved block count in two-plane mode
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         virt_block_count <= PHYS_BLOCKS;
         page_mult <= 4'h2;
      end else begin
         virt_block_count <= two_plane_mode ? (PHYS_BLOCKS >> 1)
                                            : PHYS_BLOCKS;
         page_mult <= two_plane_mode ? {1'b0, NBV_TP_PAGE_MULT}
                                     : {2'h0, NBV_SP_PAGE_MULT};
      end
   end

   // ECC cannot cover a single chip: flag it as uncorrectable
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ecc_corrupt_irq <= 1'b0;
         cmd_ready <= 1'b0;
         copy_fixed <= 1'b0;
      end else begin
         ecc_corrupt_irq <= take && cmd_has_dis && ecc_enable_option;
         cmd_ready <= sel_ready;
         copy_fixed <= |ch_fixed;
      end
   end

   // Chip enables and status straight from flops
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         ce_low_n <= '1;
         ce_high_n <= '1;
         bank_busy <= '0;
      end else begin
         ce_low_n <= ce_lo_w;
         ce_high_n <= ce_hi_w;
         bank_busy <= busy_w;
      end
   end

   // DMA data path; a disabled chip takes no data, reads undefined
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         flash_low_out <= '0;
         flash_high_out <= '0;
         dma_rdata <= '0;
      end else begin
         if (dma_valid && !low_chip_disable)
            flash_low_out <= dma_wdata[NBV_BYTE_W-1:0];
         if (dma_valid && !high_chip_disable)
            flash_high_out <= dma_wdata[NBV_BUS_W-1:NBV_BYTE_W];
         dma_rdata <= flash_rdata;
      end
   end
endmodule : nbv_top

// >>> testbench/nbv_assertions.sv
// Checker: port-level assertions for the bank virtualizer
`timescale 1ns/1ps
module nbv_assertions
   import nbv_pkg::*;
(
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic cmd_valid,
   input wire logic low_chip_disable,
   input wire logic high_chip_disable,
   input wire logic ecc_enable_option,
   input wire logic [NBV_BLOCK_W-1:0] virt_block_count,
   input wire logic [3:0] page_mult,
   input wire logic ecc_corrupt_irq,
   input wire logic copy_fixed,
   input wire logic [NBV_CHANNELS*NBV_BANKS-1:0] ce_low_n,
   input wire logic [NBV_CHANNELS*NBV_BANKS-1:0] ce_high_n,
   input wire logic [NBV_CHANNELS*NBV_BANKS-1:0] bank_busy,
   input wire logic [31:0] bank_reg_addr
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   logic [31:0] ce_on;
   logic [31:0] busy_q;
   logic [31:0] rise;
   logic pair_clash;
   logic lane_over;
   // Fold all channels into flags so one assertion covers every pair
   assign ce_on = ~ce_low_n | ~ce_high_n;
   assign rise = bank_busy & ~busy_q;
   always_comb begin
      pair_clash = 1'b0;
      lane_over = 1'b0;
      for (int c = 0; c < 4; c++) begin
         pair_clash |= |(bank_busy[c*8 +: 4] & bank_busy[c*8+4 +: 4]);
         lane_over |= ($countones(ce_on[c*8 +: 8]) > 2);
      end
   end
   // Previous busy map, to spot a bank that has just been started
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) busy_q <= '0;
      else busy_q <= bank_busy;
   end
   sequence s_xfer;
      !(ce_low_n[0] & ce_high_n[0]) [*4] ##1 (ce_low_n[0] & ce_high_n[0]);
   endsequence
   a_pair_exclusive: assert property (!pair_clash)
      else $error("paired banks busy together");
   a_two_lanes: assert property (!lane_over)
      else $error("more than two banks enabled on a channel");
   a_ce_idle_bank: assert property ((ce_on & ~bank_busy) == '0)
      else $error("chip enabled on an idle bank");
   a_start_enables: assert property (|rise |-> (ce_on & rise) == rise)
      else $error("bank started without chip enable");
   a_irq_cause: assert property (ecc_corrupt_irq |->
      $past(cmd_valid && ecc_enable_option &&
            (low_chip_disable || high_chip_disable)))
      else $error("corruption event without disabled chip and ecc");
   a_fix_pulse: assert property (copy_fixed |=> !copy_fixed)
      else $error("copy fixed pulse too long");
   a_mult_blocks: assert property (
      (page_mult == 4'h4 && virt_block_count == 16'h0800) ||
      (page_mult == 4'h2 && virt_block_count == 16'h1000))
      else $error("page multiple and block count disagree");
   a_reg_window: assert property (bank_reg_addr[31:7] == NBV_REG_BASE[31:7]
      && bank_reg_addr[1:0] == 2'h0)
      else $error("bank register address outside window");
   a_xfer_both: assert property ($fell(ce_low_n[0] & ce_high_n[0]) |-> s_xfer)
      else $error("transfer enable length wrong");
endmodule : nbv_assertions

// >>> testbench/nbv_flash_model.sv
// Flash chip model: shared ready/busy lines and read data
`timescale 1ns/1ps
module nbv_flash_model (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic [31:0] ce_low_n,
   input wire logic [31:0] ce_high_n,
   input wire logic [7:0] busy_cycles,
   output logic [15:0] rb_n,
   output logic [15:0] flash_rdata
);
   logic [31:0] rel;
   logic [31:0] rel_q;
   logic [15:0] noise_r;
   logic [7:0] cnt_r [16];
   assign rel = ce_low_n & ce_high_n;
   // Cell time starts when a bank releases its chips; banks k, k+4 share
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         rel_q <= '1;
         noise_r <= 16'h0001;
         for (int j = 0; j < 16; j++) cnt_r[j] <= 8'h00;
      end else begin
         rel_q <= rel;
         noise_r <= {noise_r[14:0], ~noise_r[15]};
         for (int j = 0; j < 16; j++) begin
            if ((rel & ~rel_q) >> ((j/4)*8 + j%4) & 32'h11)
               cnt_r[j] <= busy_cycles;
            else if (cnt_r[j] != 8'h00) cnt_r[j] <= cnt_r[j] - 8'h01;
         end
      end
   end
   // Released bus shows a changing pattern, never the last value
   always_comb begin
      for (int j = 0; j < 16; j++) rb_n[j] = (cnt_r[j] == 8'h00);
      flash_rdata = (&rel) ? noise_r : 16'h5AC3;
   end
endmodule : nbv_flash_model

// >>> testbench/nbv_top_tb_top.sv
// Testbench top for the NAND bank virtualizer
`timescale 1ns/1ps
module nbv_top_tb_top
   import nbv_pkg::*;
;
   logic sys_clk = 1'b0, arst_n = 1'b0, two_plane_mode = 1'b0;
   logic cmd_valid = 1'b0, low_chip_disable = 1'b0, high_chip_disable = 1'b0;
   logic ecc_enable_option = 1'b0, ecc_fix = 1'b0, dma_valid = 1'b0;
   logic [1:0] cmd_channel = 2'h0, cmd_op = 2'h0;
   logic [2:0] cmd_bank = 3'h0;
   logic [15:0] virtual_block = 16'h0012, virtual_page = 16'h0003;
   logic [15:0] dma_wdata = 16'hC35A, flash_rdata, rb_n, dma_rdata;
   logic [15:0] virt_block_count;
   logic [7:0] busy_cycles = 8'h06, flash_low_out, flash_high_out;
   logic [31:0] ce_low_n, ce_high_n, bank_busy, bank_reg_addr;
   logic [3:0] page_mult;
   logic [23:0] phys_row0, phys_row1;
   logic phys_two_plane;
   logic cmd_ready, ecc_corrupt_irq, copy_fixed;
   logic irq_seen = 1'b0, fix_seen = 1'b0, low_seen = 1'b0, high_seen = 1'b0;
   int n_fail = 0, n_checks = 0;
   always #4 sys_clk = ~sys_clk;
   nbv_top DUT (.sys_clk, .arst_n, .two_plane_mode, .cmd_valid, .cmd_channel,
      .cmd_bank, .cmd_op, .virtual_block, .virtual_page, .low_chip_disable,
      .high_chip_disable, .ecc_enable_option, .rb_n, .ecc_fix, .dma_valid,
      .dma_wdata, .flash_rdata, .cmd_ready, .phys_row0, .phys_row1,
      .phys_two_plane, .virt_block_count, .page_mult, .ecc_corrupt_irq,
      .copy_fixed, .ce_low_n, .ce_high_n, .bank_busy, .flash_low_out,
      .flash_high_out, .dma_rdata, .bank_reg_addr);
   nbv_flash_model FLASH (.sys_clk, .arst_n, .ce_low_n, .ce_high_n,
      .busy_cycles, .rb_n, .flash_rdata);
   // Sticky flags catch one-cycle pulses wherever they land
   always @(posedge sys_clk) begin
      irq_seen <= irq_seen | (ecc_corrupt_irq === 1'b1);
      fix_seen <= fix_seen | (copy_fixed === 1'b1);
      low_seen <= low_seen | (ce_low_n !== '1);
      high_seen <= high_seen | (ce_high_n !== '1);
   end
   task automatic give_verdict;
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic clr;
      {irq_seen, fix_seen, low_seen, high_seen} = 4'h0;
   endtask : clr
   // Hold a request until the bank turns busy; refused for hold cycles
   task automatic issue(input int ch, input int bk, input logic [1:0] op,
                        input int hold);
      int i;
      cmd_channel = 2'(ch);
      cmd_bank = 3'(bk);
      cmd_op = op;
      cmd_valid = 1'b1;
      for (i = 0; i < 300 && bank_busy[ch*8+bk] !== 1'b1; i++)
         @(negedge sys_clk);
      cmd_valid = 1'b0;
      chk(32'(i < hold || i >= 300), 32'h0);
      if (i >= 300) give_verdict();
      // One idle edge keeps back-to-back requests apart
      @(negedge sys_clk);
      chk(bank_reg_addr, NBV_REG_BASE + 32'(4*(ch*8+bk)));
   endtask : issue
   task automatic wait_idle;
      int i;
      for (i = 0; i < 600 && bank_busy !== '0; i++) @(negedge sys_clk);
      chk(32'(i >= 600), 32'h0);
      if (i >= 600) give_verdict();
   endtask : wait_idle
   task automatic t_plane;
      two_plane_mode = 1'b1;
      repeat (3) @(negedge sys_clk);
      chk({page_mult, virt_block_count}, {4'h4, 16'h0800});
      // Two-plane access joins blocks 2n and 2n+1
      issue(0, 1, NBV_OP_READ, 0);
      chk({phys_two_plane, phys_row0}, {1'b1, 24'h002403});
      chk(32'(phys_row1), 32'h0000_2503);
      // Copy-back stays on one plane even in two-plane mode
      issue(0, 2, NBV_OP_COPY, 0);
      chk({phys_two_plane, phys_row1}, {1'b0, 24'h002403});
      wait_idle();
      two_plane_mode = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk({page_mult, virt_block_count}, {4'h2, 16'h1000});
      issue(0, 1, NBV_OP_READ, 0);
      chk({phys_two_plane, phys_row0}, {1'b0, 24'h001203});
      chk(32'(phys_row1), 32'h0000_1203);
      wait_idle();
   endtask : t_plane
   // Same bank on all four channels must run at once
   task automatic t_parallel;
      busy_cycles = 8'd40;
      for (int c = 0; c < 4; c++) issue(c, 0, NBV_OP_READ, 0);
      chk({bank_busy[24], bank_busy[16], bank_busy[8], bank_busy[0]},
          32'hF);
      wait_idle();
   endtask : t_parallel
   // Partner bank must wait for the shared line to return ready
   task automatic t_pair;
      busy_cycles = 8'd30;
      issue(1, 2, NBV_OP_ERASE, 0);
      cmd_bank = 3'h6;
      @(negedge sys_clk);
      chk(32'(cmd_ready), 32'h0);
      issue(1, 6, NBV_OP_ERASE, 10);
      wait_idle();
      chk(32'(cmd_ready), 32'h1);
   endtask : t_pair
   task automatic t_ops;
      busy_cycles = 8'h04;
      for (int op = 0; op < 4; op++) begin
         clr();
         issue(2, 5, 2'(op), 0);
         wait_idle();
         chk({low_seen, high_seen}, 32'h3);
      end
   endtask : t_ops
   // Low disabled, high disabled, none disabled, all with ecc on
   task automatic t_disable;
      ecc_enable_option = 1'b1;
      for (int d = 0; d < 3; d++) begin
         clr();
         low_chip_disable = (d == 0);
         high_chip_disable = (d == 1);
         issue(3, 1, NBV_OP_PROG, 0);
         {low_chip_disable, high_chip_disable} = 2'h0;
         wait_idle();
         chk({irq_seen, low_seen, high_seen},
             {d < 2, d != 0, d != 1});
      end
      ecc_enable_option = 1'b0;
   endtask : t_disable
   task automatic t_copy;
      for (int f = 0; f < 2; f++) begin
         clr();
         ecc_fix = f[0];
         issue(0, 3, NBV_OP_COPY, 0);
         wait_idle();
         chk(32'(fix_seen), 32'(f));
      end
      ecc_fix = 1'b0;
   endtask : t_copy
   task automatic t_dma;
      dma_valid = 1'b1;
      issue(2, 0, NBV_OP_PROG, 0);
      repeat (2) @(negedge sys_clk);
      chk({flash_high_out, flash_low_out}, 32'hC35A);
      chk(32'(dma_rdata), 32'h0000_5AC3);
      wait_idle();
      dma_valid = 1'b0;
   endtask : t_dma
   // Main sequence: checks under reset, then each scenario in turn
   initial begin
      repeat (2) @(negedge sys_clk);
      chk(ce_low_n & ce_high_n, 32'hFFFF_FFFF);
      chk(bank_reg_addr, NBV_REG_BASE);
      chk({page_mult, virt_block_count}, {4'h2, 16'h1000});
      arst_n = 1'b1;
      @(negedge sys_clk);
      t_plane();
      t_parallel();
      t_pair();
      t_ops();
      t_disable();
      t_copy();
      t_dma();
      give_verdict();
   end
endmodule : nbv_top_tb_top
bind nbv_top nbv_assertions CHK (.sys_clk, .arst_n, .cmd_valid,
   .low_chip_disable, .high_chip_disable, .ecc_enable_option,
   .virt_block_count, .page_mult, .ecc_corrupt_irq, .copy_fixed,
   .ce_low_n, .ce_high_n, .bank_busy, .bank_reg_addr);
